//--- rtl/pws_defines.svh
`ifndef PWS_DEFINES_SVH
`define PWS_DEFINES_SVH

// Core clock period and the internal oscillator tick, both in ns
`define PWS_CLK_PERIOD_NS 10
`define PWS_TICK_NS 1000000
// Clock cycles per tick, derived from the two figures above
`define PWS_TICK_CYCLES (`PWS_TICK_NS / `PWS_CLK_PERIOD_NS)

// Durations in ms; one tick is one ms, so these are tick counts
`define PWS_MIN_ON_MS 16'd8
`define PWS_MIN_OFF_MS 16'd128
`define PWS_OFF_ALERT_MS 16'd1000
`define PWS_CFG_PERIOD_MS 17'd66000
`define PWS_CFG_CYCLE_MS 16'd100
`define PWS_DEBOUNCE_MS 6'd32
`define PWS_LONG_BASE_MS 15'd128

// Highest range code; the divider is four to the power of the code
`define PWS_RANGE_MAX 4'd11

`endif

//--- rtl/pws_pkg.sv
package pws_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        PWS_ST_CONFIG = 3'b000,
        PWS_ST_FROM_OFF = 3'b001,
        PWS_ST_WAKE = 3'b010,
        PWS_ST_REST = 3'b011,
        PWS_ST_SHUT = 3'b100,
        PWS_ST_OFF = 3'b101
    } pws_state_t;

endpackage : pws_pkg

//--- rtl/pws_sequencer.sv
// Operation
// - Active mode alternates wake and rest states
// - Wake powers host, exits on fall or watchdog
// - First 8ms of wake ignore exits to rest
// - Early rest-request falls are not remembered
// - Rest wakes on period, press, request high
// - Rest lasts at least 128ms, inputs deferred
// - Period-driven wake restarts interval, starts watchdog
// - Interval counter runs on through rest
// - Each press restarts the interval counter
// - Long press enters shutting-off, off alert low
// - Shutting-off lasts 1s then all off
// - Long request-high also shuts down
// - Short press only powers host
// - Dormant press returns via from-off wake
// - On alert low in first wake after dormant
// - Power-up setting picks active or dormant start
// - Configuration re-read every 66s and exits
// - Configuration cycle takes 0.1s
// - Interval is period times range divider
// - Power enable polarity selectable
// - On alert stays low through that wake
// - Debounced button output follows button
// - Watchdog still runs during long request-high
`timescale 1ns/1ps
`include "pws_defines.svh"

module pws_sequencer
    import pws_pkg::*;
#(
    parameter int TICK_CYCLES = `PWS_TICK_CYCLES
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Pins from the host and the pushbutton
    input wire logic button_n_in,
    input wire logic rest_req_in,
    // Quasi-static settings, sampled in a configuration cycle and by the 66s re-read while active
    input wire logic [15:0] period_setting_in,
    input wire logic [3:0] range_setting_in,
    input wire logic [2:0] long_hold_setting_in,
    input wire logic [15:0] max_awake_setting_in,
    input wire logic power_up_active_in,
    input wire logic enable_active_low_in,
    // Outputs toward the host
    output logic power_en_out,
    output logic on_alert_n_out,
    output logic off_alert_n_out,
    output logic debounced_button_out
);

    // Interval in ms: period setting times four to the range code
    function automatic logic [39:0] interval_ms(input logic [15:0] per,
                                                input logic [3:0] rng);
        logic [3:0] r;
        r = (rng > `PWS_RANGE_MAX) ? `PWS_RANGE_MAX : rng;
        interval_ms = {24'h0, per} << {r, 1'b0};
    endfunction : interval_ms

    // Synchronisers for the two pins
    logic btn_s1, btn_s2, req_s1, req_s2;
    logic req_d; // Previous synchronised request, for edge detect
    logic next_req_d;
    // Millisecond tick generator
    logic [16:0] tick_cnt, next_tick_cnt;
    logic tick;
    // Debounce
    logic [5:0] deb_cnt, next_deb_cnt;
    logic btn_db, next_btn_db; // Debounced level, 1 = released
    // Sequencer
    pws_state_t state, next_state;
    logic [15:0] st_cnt, next_st_cnt; // ms since state entry
    logic [14:0] long_cnt, next_long_cnt;
    logic [39:0] period_cnt, next_period_cnt;
    logic period_due, next_period_due;
    logic press_pend, next_press_pend;
    logic from_off, next_from_off;
    logic [16:0] cfg_cnt, next_cfg_cnt;
    // Latched settings
    logic [15:0] per_l, next_per_l, max_l, next_max_l;
    logic [3:0] rng_l, next_rng_l;
    logic [2:0] long_l, next_long_l;
    logic pol_l, next_pol_l;
    // Output flops
    logic pwr, next_pwr;
    logic en_pin, next_en_pin;
    logic on_al_n, next_on_al_n, off_al_n, next_off_al_n;
    // Decodes
    logic press, req_fall, active, in_wake, long_hit, min_on_ok;
    logic [39:0] ivl;
    logic [14:0] long_lim;

    // Two-flop synchronisers; first stage feeds only the second
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            btn_s1 <= 1'b1;
            btn_s2 <= 1'b1;
            req_s1 <= 1'b0;
            req_s2 <= 1'b0;
        end else begin
            btn_s1 <= button_n_in;
            btn_s2 <= btn_s1;
            req_s1 <= rest_req_in;
            req_s2 <= req_s1;
        end
    end

    // Next-state logic for every timer and the sequencer
    always_comb begin
        // Hold by default, except the tick counter and req_d
        next_tick_cnt = tick_cnt + 17'd1;
        next_deb_cnt = deb_cnt;
        next_btn_db = btn_db;
        next_req_d = req_s2;
        next_state = state;
        next_st_cnt = st_cnt;
        next_long_cnt = long_cnt;
        next_period_cnt = period_cnt;
        next_period_due = period_due;
        next_press_pend = press_pend;
        next_from_off = from_off;
        next_cfg_cnt = cfg_cnt;
        next_per_l = per_l;
        next_rng_l = rng_l;
        next_long_l = long_l;
        next_max_l = max_l;
        next_pol_l = pol_l;
        next_pwr = pwr;
        next_on_al_n = on_al_n;
        next_off_al_n = off_al_n;

        // Common ms tick drives every timer
        tick = (tick_cnt == 17'(TICK_CYCLES - 1));
        if (tick) begin
            next_tick_cnt = 17'h0;
        end

        // Debounce: level must differ for the full time to flip
        if (btn_s2 == btn_db) begin
            next_deb_cnt = 6'h0;
        end else if (tick) begin
            if (deb_cnt == `PWS_DEBOUNCE_MS - 6'd1) begin
                next_btn_db = btn_s2;
                next_deb_cnt = 6'h0;
            end else begin
                next_deb_cnt = deb_cnt + 6'd1;
            end
        end
        press = btn_db & ~next_btn_db;
        req_fall = req_d & ~req_s2;

        active = (state == PWS_ST_WAKE) || (state == PWS_ST_FROM_OFF)
            || (state == PWS_ST_REST);
        in_wake = (state == PWS_ST_WAKE) || (state == PWS_ST_FROM_OFF);
        min_on_ok = (st_cnt >= `PWS_MIN_ON_MS);
        ivl = interval_ms(per_l, rng_l);
        long_lim = `PWS_LONG_BASE_MS << long_l;

        // State-age counter, saturating
        if (tick && st_cnt != 16'hffff) begin
            next_st_cnt = st_cnt + 16'd1;
        end

        // Long hold: button low anywhere active, request high in wake only
        if (active && (!btn_db || (req_s2 && in_wake))) begin
            if (tick && long_cnt != 15'h7fff) begin
                next_long_cnt = long_cnt + 15'd1;
            end
        end else begin
            next_long_cnt = 15'h0;
        end
        long_hit = (long_cnt >= long_lim);

        // Interval counter keeps running whatever the active state
        if (active && tick) begin
            if (period_cnt >= ivl - 40'd1) begin
                next_period_due = 1'b1;
            end else begin
                next_period_cnt = period_cnt + 40'd1;
            end
        end
        if (press) begin
            next_period_cnt = 40'h0;
            next_period_due = 1'b0;
        end

        // Periodic re-read of the settings while active
        if (active && tick) begin
            if (cfg_cnt == `PWS_CFG_PERIOD_MS - 17'd1) begin
                next_cfg_cnt = 17'h0;
                next_per_l = period_setting_in;
                next_rng_l = range_setting_in;
                next_long_l = long_hold_setting_in;
                next_max_l = max_awake_setting_in;
                next_pol_l = enable_active_low_in;
            end else begin
                next_cfg_cnt = cfg_cnt + 17'd1;
            end
        end

        // A press during rest is kept until rest may end
        if (state == PWS_ST_REST && press) begin
            next_press_pend = 1'b1;
        end

        case (state)
            PWS_ST_CONFIG: begin
                // Settings other than polarity applied only at the end of the cycle
                next_pwr = 1'b0;
                // Track the polarity pin here so the host sees off, not on, after reset
                next_pol_l = enable_active_low_in;
                if (tick && st_cnt >= `PWS_CFG_CYCLE_MS - 16'd1) begin
                    next_per_l = period_setting_in;
                    next_rng_l = range_setting_in;
                    next_long_l = long_hold_setting_in;
                    next_max_l = max_awake_setting_in;
                    next_pol_l = enable_active_low_in;
                    next_cfg_cnt = 17'h0;
                    next_st_cnt = 16'h0;
                    if (from_off || power_up_active_in) begin
                        next_state = PWS_ST_FROM_OFF;
                        next_pwr = 1'b1;
                        next_on_al_n = 1'b0;
                        next_period_cnt = 40'h0;
                        next_period_due = 1'b0;
                    end else begin
                        next_state = PWS_ST_OFF;
                    end
                    next_from_off = 1'b0;
                end
            end
            PWS_ST_FROM_OFF, PWS_ST_WAKE: begin
                next_pwr = 1'b1;
                if (long_hit) begin
                    // Long press or long request-high: warn, then cut
                    next_state = PWS_ST_SHUT;
                    next_off_al_n = 1'b0;
                    next_on_al_n = 1'b1;
                    next_st_cnt = 16'h0;
                end else if (min_on_ok && (req_fall || st_cnt >= max_l)) begin
                    next_state = PWS_ST_REST;
                    next_pwr = 1'b0;
                    next_on_al_n = 1'b1;
                    next_st_cnt = 16'h0;
                    next_press_pend = 1'b0;
                end
            end
            PWS_ST_REST: begin
                next_pwr = 1'b0;
                if (st_cnt >= `PWS_MIN_OFF_MS
                        && (period_due || press_pend || press || req_s2)) begin
                    next_state = PWS_ST_WAKE;
                    next_pwr = 1'b1;
                    next_st_cnt = 16'h0;
                    next_period_cnt = 40'h0;
                    next_period_due = 1'b0;
                    next_press_pend = 1'b0;
                end
            end
            PWS_ST_SHUT: begin
                // Host stays powered while the off alert is shown
                next_pwr = 1'b1;
                next_off_al_n = 1'b0;
                if (st_cnt >= `PWS_OFF_ALERT_MS) begin
                    next_state = PWS_ST_OFF;
                    next_pwr = 1'b0;
                    next_off_al_n = 1'b1;
                    next_st_cnt = 16'h0;
                end
            end
            PWS_ST_OFF: begin
                // Interval timer held at zero; a fresh press leaves dormant mode
                next_pwr = 1'b0;
                next_period_cnt = 40'h0;
                next_period_due = 1'b0;
                next_press_pend = 1'b0;
                if (press) begin
                    next_state = PWS_ST_CONFIG;
                    next_from_off = 1'b1;
                    next_st_cnt = 16'h0;
                end
            end
            default: begin
                next_state = PWS_ST_CONFIG;
                next_st_cnt = 16'h0;
                next_pwr = 1'b0;
            end
        endcase

        // Pin level after the polarity choice
        next_en_pin = next_pwr ^ next_pol_l;
    end

    // State registers; power-on starts a configuration cycle
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            tick_cnt <= 17'h0;
            deb_cnt <= 6'h0;
            btn_db <= 1'b1;
            req_d <= 1'b0;
            state <= PWS_ST_CONFIG;
            st_cnt <= 16'h0;
            long_cnt <= 15'h0;
            period_cnt <= 40'h0;
            period_due <= 1'b0;
            press_pend <= 1'b0;
            from_off <= 1'b0;
            cfg_cnt <= 17'h0;
            per_l <= 16'h0;
            rng_l <= 4'h0;
            long_l <= 3'h0;
            max_l <= 16'h0;
            pol_l <= 1'b0;
            pwr <= 1'b0;
            en_pin <= 1'b0;
            on_al_n <= 1'b1;
            off_al_n <= 1'b1;
        end else begin
            tick_cnt <= next_tick_cnt;
            deb_cnt <= next_deb_cnt;
            btn_db <= next_btn_db;
            req_d <= next_req_d;
            state <= next_state;
            st_cnt <= next_st_cnt;
            long_cnt <= next_long_cnt;
            period_cnt <= next_period_cnt;
            period_due <= next_period_due;
            press_pend <= next_press_pend;
            from_off <= next_from_off;
            cfg_cnt <= next_cfg_cnt;
            per_l <= next_per_l;
            rng_l <= next_rng_l;
            long_l <= next_long_l;
            max_l <= next_max_l;
            pol_l <= next_pol_l;
            pwr <= next_pwr;
            en_pin <= next_en_pin;
            on_al_n <= next_on_al_n;
            off_al_n <= next_off_al_n;
        end
    end

    // All outputs straight from flops
    assign power_en_out = en_pin;
    assign on_alert_n_out = on_al_n;
    assign off_alert_n_out = off_al_n;
    assign debounced_button_out = btn_db;

endmodule : pws_sequencer

//--- dv/pws_checker.sv
`timescale 1ns/1ps
module pws_checker #(
    parameter int TICK_CYCLES = 10
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // Watched inputs
    input wire logic button_n_in,
    input wire logic rest_req_in,
    input wire logic [15:0] max_awake_setting_in,
    input wire logic enable_active_low_in,
    // Watched outputs
    input wire logic power_en_out,
    input wire logic on_alert_n_out,
    input wire logic off_alert_n_out,
    input wire logic debounced_button_out
);
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);
    // Power as the host sees it, whichever pin polarity is set
    wire on_l = power_en_out ^ enable_active_low_in;
    int on_cnt; // Clocks since power on or from-off entry
    int off_cnt; // Clocks since power off; starts high so boot is no short rest
    int al_cnt; // Clocks the off alert has been low
    int btn_cnt; // Clocks the raw button has been steady
    int boot_cnt; // Clocks since reset release, saturating
    logic boot_ok; // Pin polarity settled; the first edges after reset may flip it
    assign boot_ok = (boot_cnt > 2);
    // Age counters; a synchronous clear is enough for checking
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            on_cnt <= 0;
            off_cnt <= 1000000;
            al_cnt <= 0;
            btn_cnt <= 0;
            boot_cnt <= 0;
        end else begin
            boot_cnt <= boot_ok ? boot_cnt : boot_cnt + 1;
            on_cnt <= ($rose(on_l) || $fell(on_alert_n_out)) ? 0 : on_cnt + 1;
            off_cnt <= ($fell(on_l) && boot_ok) ? 0 : off_cnt + 1;
            al_cnt <= off_alert_n_out ? 0 : al_cnt + 1;
            btn_cnt <= $changed(button_n_in) ? 0 : btn_cnt + 1;
        end
    end
    a_min_on_time: assert property ($fell(on_l) && boot_ok |-> on_cnt >= 7 * TICK_CYCLES)
        else $error("power dropped inside the minimum on time");
    a_min_off_time: assert property ($rose(on_l) |-> off_cnt >= 127 * TICK_CYCLES)
        else $error("power returned inside the minimum off time");
    a_watchdog_bound: assert property ($fell(on_l) && !$rose(off_alert_n_out) && boot_ok |->
        on_cnt <= (max_awake_setting_in + 2) * TICK_CYCLES)
        else $error("power stayed on past the maximum awake time");
    a_on_alert_power: assert property (!on_alert_n_out |-> on_l)
        else $error("on alert low while power is off");
    a_off_alert_power: assert property (!off_alert_n_out |-> on_l)
        else $error("off alert low while power is off");
    a_alerts_apart: assert property (on_alert_n_out || off_alert_n_out)
        else $error("both alerts low together");
    a_off_alert_len: assert property ($rose(off_alert_n_out) |->
        al_cnt inside {[999 * TICK_CYCLES : 1001 * TICK_CYCLES]} && !on_l)
        else $error("off alert length wrong or power left on");
    a_shut_cause: assert property ($fell(off_alert_n_out) |->
        !debounced_button_out || rest_req_in)
        else $error("shutting off without a long hold");
    a_debounce_steady: assert property ($changed(debounced_button_out) |->
        btn_cnt >= 31 * TICK_CYCLES && debounced_button_out == button_n_in)
        else $error("button echo moved without a steady button");
    // Main scenarios reached
    c_shut: cover property ($fell(off_alert_n_out));
    c_from_off: cover property ($fell(on_alert_n_out));
    c_press: cover property ($fell(debounced_button_out));
endmodule : pws_checker

bind pws_sequencer pws_checker #(.TICK_CYCLES(TICK_CYCLES)) pws_checker_i (
    .core_clk_in(core_clk_in), .rst_in(rst_in), .button_n_in(button_n_in),
    .rest_req_in(rest_req_in), .max_awake_setting_in(max_awake_setting_in),
    .enable_active_low_in(enable_active_low_in), .power_en_out(power_en_out),
    .on_alert_n_out(on_alert_n_out), .off_alert_n_out(off_alert_n_out),
    .debounced_button_out(debounced_button_out));

//--- dv/pws_host_model.sv
`timescale 1ns/1ps
module pws_host_model (
    // Clock and the power the host receives
    input wire logic core_clk_in,
    input wire logic host_on_in,
    // Behaviour chosen by the bench
    input wire logic active_in,
    input wire logic hold_high_in,
    // Request line toward the sequencer
    output logic rest_req_out
);
    int age; // Clocks since the host powered up
    initial begin
        rest_req_out = 1'b0;
        age = 0;
    end
    // A fast host ends its task inside the minimum on time, so it toggles
    always @(posedge core_clk_in) begin
        age <= host_on_in ? age + 1 : 0;
        if (hold_high_in) begin
            rest_req_out <= 1'b1;
        end else if (host_on_in && active_in && age > 40 && age % 4 == 0) begin
            rest_req_out <= ~rest_req_out;
        end else if (!host_on_in || !active_in) begin
            rest_req_out <= 1'b0; // Unpowered or passive host; line pulled low
        end
    end
endmodule : pws_host_model

//--- dv/tb_pws_sequencer.sv
`timescale 1ns/1ps
module tb_pws_sequencer;
    localparam int TC = 10; // Clocks per tick; keeps second-long waits short
    // Expected change of {power, on alert, off alert}, delay window in ticks
    typedef struct {
        logic [2:0] val;
        int lo;
        int hi;
    } pws_note_t;
    pws_note_t q[$];
    logic clk, rst, btn_n, req, pol, act, hold, watch, pen, onal, offal, dbtn;
    logic [15:0] per, ma;
    logic [2:0] prev;
    int seed, cyc, last_ev, err_count, n_tests;
    wire [2:0] cur = {pen ^ pol, onal, offal}; // Power as the host sees it
    pws_sequencer #(.TICK_CYCLES(TC)) pws_sequencer_i (
        .core_clk_in(clk), .rst_in(rst), .button_n_in(btn_n), .rest_req_in(req),
        .period_setting_in(per), .range_setting_in(4'h0), .long_hold_setting_in(3'h0),
        .max_awake_setting_in(ma), .power_up_active_in(1'b1), .enable_active_low_in(pol),
        .power_en_out(pen), .on_alert_n_out(onal), .off_alert_n_out(offal),
        .debounced_button_out(dbtn));
    pws_host_model pws_host_model_i (.core_clk_in(clk), .host_on_in(cur[2]),
        .active_in(act), .hold_high_in(hold), .rest_req_out(req));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report
    task automatic note(input logic [2:0] val, input int lo, input int hi);
        q.push_back('{val, lo, hi});
    endtask : note
    task automatic ticks(input int n);
        repeat (n * TC) @(posedge clk);
    endtask : ticks
    // Bounded wait until every noted change has been seen
    task automatic drain(input int lim);
        for (int k = 0; k < lim * TC && q.size() > 0; k++) begin
            @(posedge clk);
        end
        check("pending changes", q.size(), 0);
    endtask : drain
    // Pairs each output change with the oldest note; also cuts a hang short
    always @(posedge clk) begin
        pws_note_t n;
        int d;
        d = cyc - last_ev;
        cyc <= cyc + 1;
        prev <= cur;
        if (cur !== prev) begin
            last_ev <= cyc;
        end
        if (watch && cur !== prev) begin
            if (q.size() == 0) begin
                check("spare change", cur, prev);
            end else begin
                n = q.pop_front();
                check("outputs", cur, n.val);
                check("delay", d >= n.lo * TC && d <= n.hi * TC, 1'b1);
            end
        end
        if (cyc == 95000) begin
            err_count++;
            final_report();
        end
    end
    // One pass: power-up, passive, active, press, request high, shutdown, return
    task automatic run(input int r);
        int m;
        int p;
        int len;
        m = (r == 0) ? 40 : 200;
        p = 400 + ($random(seed) & 63);
        len = 40 + ($random(seed) & 31);
        @(posedge clk);
        rst <= 1'b1;
        watch <= 1'b0;
        pol <= r[0];
        ma <= m[15:0];
        per <= p[15:0];
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        ticks(95);
        check("power in config", pen, pol);
        ticks(15);
        check("power at start", pen, !pol);
        check("on alert", onal, 1'b0);
        watch <= 1'b1;
        note(3'h3, m - 1, m + 2);
        note(3'h7, p - m - 1, p - m + 2);
        note(3'h3, m - 1, m + 2);
        drain(p + m + 60);
        act <= 1'b1;
        note(3'h7, p - m - 1, p - m + 2);
        note(3'h3, 7, 10);
        drain(p + 60);
        act <= 1'b0;
        note(3'h7, 127, 131);
        note(3'h3, m - 1, m + 2);
        btn_n <= 1'b0;
        ticks(38);
        check("button echo", dbtn, 1'b0);
        ticks(len - 38);
        btn_n <= 1'b1;
        drain(m + 200);
        check("button echo", dbtn, 1'b1);
        hold <= 1'b1;
        note(3'h7, 127, 131);
        if (r == 0) begin
            note(3'h3, m - 1, m + 2);
            drain(m + 200);
            hold <= 1'b0;
            btn_n <= 1'b0;
            note(3'h7, 127, 131);
            note(3'h6, 20, 50);
            note(3'h3, 999, 1002);
            ticks(250);
            btn_n <= 1'b1;
        end else begin
            note(3'h6, 127, 131);
            note(3'h3, 999, 1002);
        end
        drain(1400);
        hold <= 1'b0;
        btn_n <= 1'b0;
        note(3'h5, 130, 140);
        note(3'h3, m - 1, m + 2);
        ticks(50);
        btn_n <= 1'b1;
        drain(m + 200);
    endtask : run
    initial begin
        seed = 32'hd925f66e;
        rst = 1'b1;
        btn_n = 1'b1;
        act = 1'b0;
        hold = 1'b0;
        watch = 1'b0;
        pol = 1'b0;
        ma = 16'h0028;
        per = 16'h0190;
        run(0);
        run(1);
        final_report();
    end
endmodule : tb_pws_sequencer
